// >>> src/buck_seq_pkg.sv
// package: constants, types and state encodings for the dual buck sequencer
package buck_seq_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int POWERUP_US = 400;
    localparam int NOSTART_US = 100;
    localparam int PG_FILTER_US = 120;
    localparam int SYNC_LOSS_US = 10;
    localparam int DEFAULT_FREQ_HZ = 2_000_000;
    localparam int POWERUP_CYC = POWERUP_US * (CLK_HZ / 1_000_000);
    localparam int NOSTART_CYC = NOSTART_US * (CLK_HZ / 1_000_000);
    localparam int PG_FILTER_CYC = PG_FILTER_US * (CLK_HZ / 1_000_000);
    localparam int SYNC_LOSS_CYC = SYNC_LOSS_US * (CLK_HZ / 1_000_000);
    // oscillator phase accumulator: 16 bits wide
    localparam int PHASE_W = 16;
    localparam logic [PHASE_W-1:0] DEFAULT_INC = 16'h147A;
    localparam logic [PHASE_W-1:0] HALF_PHASE = 16'h8000;
    localparam int CNT_W = 14;
    localparam int SST_W = 10;

    typedef enum logic [1:0] {
        MODE_SKIP = 2'b00,
        MODE_FCM = 2'b01,
        MODE_SLEEP = 2'b11
    } mode_t;

    typedef enum logic [1:0] {
        CH_OFF = 2'b00,
        CH_WAIT = 2'b01,
        CH_NOSTART = 2'b11,
        CH_RUN = 2'b10
    } ch_state_t;

    typedef struct packed {
        logic high_on;
        logic low_on;
        logic drive_en;
    } sw_drive_t;

    typedef struct packed {
        logic peak_trip;
        logic zero_current;
        logic reverse_limit;
        logic valley_over;
        logic above_98;
        logic below_97;
        logic above_110;
        logic below_1078;
        logic above_target;
    } ch_sense_t;
endpackage : buck_seq_pkg

// >>> src/dual_buck_sequencing_control.sv
// dual buck sequencer, oscillator, mode decode and power ok supervisor
`timescale 1ns/10ps
module dual_buck_sequencing_control #(
    parameter int POWERUP_CYCLES = buck_seq_pkg::POWERUP_CYC,
    parameter int NOSTART_CYCLES = buck_seq_pkg::NOSTART_CYC,
    parameter int PG_CYCLES = buck_seq_pkg::PG_FILTER_CYC,
    parameter int LOSS_CYCLES = buck_seq_pkg::SYNC_LOSS_CYC
) (
    // clocks and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic sync_clk,
    // enables and supervisors
    input wire logic chan1_enable_in,
    input wire logic chan2_enable_in,
    input wire logic input_undervoltage_lockout,
    input wire logic overtemperature_flag,
    // mode pin: level low/high and floating detect
    input wire logic mode_level,
    input wire logic mode_floating,
    // per channel comparators
    input wire buck_seq_pkg::ch_sense_t feedback_sense1,
    input wire buck_seq_pkg::ch_sense_t feedback_sense2,
    // switch node drives
    output buck_seq_pkg::sw_drive_t switch_node1,
    output buck_seq_pkg::sw_drive_t switch_node2,
    // soft start ramps and status
    output logic [buck_seq_pkg::SST_W-1:0] soft_start1,
    output logic [buck_seq_pkg::SST_W-1:0] soft_start2,
    output logic sync_locked,
    output buck_seq_pkg::mode_t active_mode,
    // open-drain power ok
    output logic power_ok_out,
    output logic power_ok_oe
);
    localparam int CNT_MAX = 1 << buck_seq_pkg::CNT_W;
    if (POWERUP_CYCLES < 1 || POWERUP_CYCLES >= CNT_MAX) begin : g_bad_powerup
        $error("POWERUP_CYCLES out of range");
    end
    if (NOSTART_CYCLES < 1 || NOSTART_CYCLES >= CNT_MAX || PG_CYCLES < 1
        || PG_CYCLES >= CNT_MAX || LOSS_CYCLES < 1 || LOSS_CYCLES >= CNT_MAX) begin : g_bad_counts
        $error("interval counts out of range");
    end

    localparam int W = buck_seq_pkg::CNT_W;
    localparam int PW = buck_seq_pkg::PHASE_W;

    // link domain: sync edge toggles on its own clock
    // power-up value: the link clock may stand still through reset
    logic sync_tog_reg = 1'b0;
    always_ff @(posedge sync_clk) begin
        sync_tog_reg <= ~sync_tog_reg;
    end

    typedef struct packed {
        logic [2:0] tog_sync;
        logic [1:0] en1_s0, en1_s1;
        logic uv_s0, uv_s1, ot_s0, ot_s1;
        logic ml_s0, ml_s1, mf_s0, mf_s1;
        logic hot;
        logic [W-1:0] pu_cnt;
        logic pu_done;
        buck_seq_pkg::ch_state_t [1:0] st;
        logic [1:0][W-1:0] ns_cnt;
        logic [1:0][buck_seq_pkg::SST_W-1:0] ss;
        logic [1:0] hs, ls, skip, good, ov, asleep;
        logic [PW-1:0] phase;
        logic [PW-1:0] inc;
        logic [W-1:0] loss_cnt;
        logic [W-1:0] per_cnt;
        logic [W-1:0] ext_per;
        logic locked;
        logic [W-1:0] pg_cnt;
        logic pg;
    } state_t;

    state_t q_reg, q_next;

    function automatic buck_seq_pkg::mode_t decode_mode(input logic lvl, input logic flt);
        if (flt) begin
            return buck_seq_pkg::MODE_FCM;
        end
        return lvl ? buck_seq_pkg::MODE_SLEEP : buck_seq_pkg::MODE_SKIP;
    endfunction : decode_mode

    buck_seq_pkg::ch_sense_t sense [2];
    assign sense[0] = feedback_sense1;
    assign sense[1] = feedback_sense2;

    logic [1:0] en_s;
    logic sync_edge, cyc_start, half_start, fault;
    buck_seq_pkg::mode_t mode;
    logic [PW:0] phase_sum;
    logic [PW-1:0] half_prev, half_now;
    logic want;

    always_comb begin
        q_next = q_reg;
        // two-flop synchronisers, three flops for the sync toggle
        q_next.en1_s0 = {chan2_enable_in, chan1_enable_in};
        q_next.en1_s1 = q_reg.en1_s0;
        q_next.uv_s0 = input_undervoltage_lockout;
        q_next.uv_s1 = q_reg.uv_s0;
        q_next.ot_s0 = overtemperature_flag;
        q_next.ot_s1 = q_reg.ot_s0;
        q_next.ml_s0 = mode_level;
        q_next.ml_s1 = q_reg.ml_s0;
        q_next.mf_s0 = mode_floating;
        q_next.mf_s1 = q_reg.mf_s0;
        q_next.tog_sync = {q_reg.tog_sync[1:0], sync_tog_reg};
        en_s = q_reg.en1_s1;
        sync_edge = q_reg.tog_sync[2] ^ q_reg.tog_sync[1];

        // thermal flag: registered copy of the synchronised overtemperature input
        q_next.hot = q_reg.ot_s1;
        fault = q_reg.uv_s1 | q_reg.hot;

        // external clock period measure and loss detect
        q_next.per_cnt = (q_reg.per_cnt == {W{1'b1}}) ? q_reg.per_cnt : q_reg.per_cnt + 1'b1;
        if (sync_edge) begin
            q_next.ext_per = q_reg.per_cnt;
            q_next.per_cnt = '0;
            q_next.loss_cnt = '0;
            q_next.locked = 1'b1;
        end else if (q_reg.locked) begin
            q_next.loss_cnt = q_reg.loss_cnt + 1'b1;
            if (q_reg.loss_cnt >= W'(LOSS_CYCLES - 1)) begin
                q_next.locked = 1'b0;
            end
        end
        mode = q_reg.locked ? buck_seq_pkg::MODE_FCM : decode_mode(q_reg.ml_s1, q_reg.mf_s1);

        // oscillator: glide increment toward target one step per cycle, or one step per sync edge while locked
        phase_sum = {1'b0, q_reg.phase} + {1'b0, q_reg.inc};
        cyc_start = phase_sum[PW];
        half_prev = q_reg.phase;
        half_now = phase_sum[PW-1:0];
        half_start = (half_prev < buck_seq_pkg::HALF_PHASE) && (half_now >= buck_seq_pkg::HALF_PHASE);
        q_next.phase = phase_sum[PW-1:0];
        if (q_reg.locked && sync_edge) begin
            // reset phase to zero at the edge
            q_next.phase = '0;
            cyc_start = 1'b1;
            half_start = 1'b0;
            if (q_reg.ext_per != '0 && q_reg.ext_per < W'(12)) begin
                q_next.inc = q_reg.inc + 1'b1;
            end else if (q_reg.ext_per > W'(12)) begin
                q_next.inc = q_reg.inc - 1'b1;
            end
        end else if (!q_reg.locked) begin
            if (q_reg.inc < buck_seq_pkg::DEFAULT_INC) begin
                q_next.inc = q_reg.inc + 1'b1;
            end else if (q_reg.inc > buck_seq_pkg::DEFAULT_INC) begin
                q_next.inc = q_reg.inc - 1'b1;
            end
        end

        // shared power-up delay
        if (!(|en_s)) begin
            q_next.pu_cnt = '0;
            q_next.pu_done = 1'b0;
        end else if (!q_reg.pu_done) begin
            q_next.pu_cnt = q_reg.pu_cnt + 1'b1;
            if (q_reg.pu_cnt >= W'(POWERUP_CYCLES - 1)) begin
                q_next.pu_done = 1'b1;
            end
        end

        for (int i = 0; i < 2; i++) begin
            unique case (q_reg.st[i])
                buck_seq_pkg::CH_OFF: begin
                    if (en_s[i]) begin
                        q_next.st[i] = buck_seq_pkg::CH_WAIT;
                    end
                end
                buck_seq_pkg::CH_WAIT: begin
                    if (q_reg.pu_done) begin
                        q_next.st[i] = buck_seq_pkg::CH_NOSTART;
                        q_next.ns_cnt[i] = '0;
                    end
                end
                buck_seq_pkg::CH_NOSTART: begin
                    q_next.ns_cnt[i] = q_reg.ns_cnt[i] + 1'b1;
                    if (q_reg.ns_cnt[i] >= W'(NOSTART_CYCLES - 1)) begin
                        q_next.st[i] = buck_seq_pkg::CH_RUN;
                    end
                end
                buck_seq_pkg::CH_RUN: begin
                end
            endcase
            if (!en_s[i]) begin
                q_next.st[i] = buck_seq_pkg::CH_OFF;
            end

            // soft start ramp, discharged on fault
            if (fault || q_reg.st[i] != buck_seq_pkg::CH_RUN) begin
                q_next.ss[i] = '0;
            end else if (cyc_start && q_reg.ss[i] != {buck_seq_pkg::SST_W{1'b1}}) begin
                q_next.ss[i] = q_reg.ss[i] + 1'b1;
            end

            // switching cycle
            if (q_reg.st[i] != buck_seq_pkg::CH_RUN || fault) begin
                q_next.hs[i] = 1'b0;
                q_next.ls[i] = 1'b0;
                q_next.skip[i] = 1'b0;
                q_next.asleep[i] = 1'b0;
            end else begin
                if (mode == buck_seq_pkg::MODE_SLEEP && sense[i].above_target) begin
                    q_next.asleep[i] = 1'b1;
                end else if (!sense[i].above_target) begin
                    q_next.asleep[i] = 1'b0;
                end
                if (i == 0 ? cyc_start : half_start) begin
                    q_next.skip[i] = sense[i].valley_over;
                    if (sense[i].valley_over || sense[i].above_110 || q_next.asleep[i]
                        || (mode == buck_seq_pkg::MODE_SKIP && sense[i].above_target)) begin
                        q_next.hs[i] = 1'b0;
                        q_next.ls[i] = q_reg.ls[i] & ~sense[i].zero_current;
                    end else begin
                        q_next.hs[i] = 1'b1;
                        q_next.ls[i] = 1'b0;
                    end
                end else if (q_reg.hs[i] && (sense[i].peak_trip || sense[i].above_110)) begin
                    q_next.hs[i] = 1'b0;
                    q_next.ls[i] = 1'b1;
                end
                if (sense[i].above_110) begin
                    q_next.hs[i] = 1'b0;
                end
                if (q_reg.ls[i]) begin
                    if (mode != buck_seq_pkg::MODE_FCM && sense[i].zero_current) begin
                        q_next.ls[i] = 1'b0;
                    end else if (mode == buck_seq_pkg::MODE_FCM && sense[i].reverse_limit) begin
                        q_next.ls[i] = 1'b0;
                    end
                end
            end

            // good flag with hysteresis and overvoltage window
            if (sense[i].above_98) begin
                q_next.good[i] = 1'b1;
            end else if (sense[i].below_97) begin
                q_next.good[i] = 1'b0;
            end
            if (sense[i].above_110) begin
                q_next.ov[i] = 1'b1;
            end else if (sense[i].below_1078) begin
                q_next.ov[i] = 1'b0;
            end
        end

        // power ok filter: a change of wanted level waits the full interval; fault or no enable clears it at once
        begin
            want = (|en_s) && !fault
                && (!en_s[0] || (q_reg.good[0] && !q_reg.ov[0]))
                && (!en_s[1] || (q_reg.good[1] && !q_reg.ov[1]));
            if (!(|en_s) || fault) begin
                q_next.pg = 1'b0;
                q_next.pg_cnt = '0;
            end else if (want == q_reg.pg) begin
                q_next.pg_cnt = '0;
            end else if (q_reg.pg_cnt >= W'(PG_CYCLES - 1)) begin
                q_next.pg = want;
                q_next.pg_cnt = '0;
            end else begin
                q_next.pg_cnt = q_reg.pg_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            q_reg <= '0;
            q_reg.inc <= buck_seq_pkg::DEFAULT_INC;
        end else begin
            q_reg <= q_next;
        end
    end

    // outputs
    assign switch_node1 = '{high_on: q_reg.hs[0], low_on: q_reg.ls[0],
                            drive_en: q_reg.st[0] == buck_seq_pkg::CH_RUN};
    assign switch_node2 = '{high_on: q_reg.hs[1], low_on: q_reg.ls[1],
                            drive_en: q_reg.st[1] == buck_seq_pkg::CH_RUN};
    assign soft_start1 = q_reg.ss[0];
    assign soft_start2 = q_reg.ss[1];
    assign sync_locked = q_reg.locked;
    assign active_mode = q_reg.locked ? buck_seq_pkg::MODE_FCM
                                      : decode_mode(q_reg.ml_s1, q_reg.mf_s1);
    assign power_ok_out = 1'b0;
    assign power_ok_oe = ~q_reg.pg;

    // checks
    property p_pg_off;
        @(posedge sys_clk) disable iff (!rst_b)
            (q_reg.en1_s1 == 2'b00) |=> !q_reg.pg;
    endproperty
    a_pg_off: assert property (p_pg_off) else $error("power ok high with no enable");

    property p_pg_delay;
        @(posedge sys_clk) disable iff (!rst_b)
            $rose(q_reg.pg) |-> $past(q_reg.pg_cnt) == W'(PG_CYCLES - 1);
    endproperty
    a_pg_delay: assert property (p_pg_delay) else $error("power ok rose early");

    property p_ov_hs;
        @(posedge sys_clk) disable iff (!rst_b)
            feedback_sense1.above_110 |=> !q_reg.hs[0];
    endproperty
    a_ov_hs: assert property (p_ov_hs) else $error("high side on in overvoltage");

    property p_ov_hs2;
        @(posedge sys_clk) disable iff (!rst_b)
            feedback_sense2.above_110 |=> !q_reg.hs[1];
    endproperty
    a_ov_hs2: assert property (p_ov_hs2) else $error("high side 2 on in overvoltage");

    property p_off_float;
        @(posedge sys_clk) disable iff (!rst_b)
            (q_reg.en1_s1 == 2'b00) |=> !switch_node1.drive_en && !switch_node2.drive_en;
    endproperty
    a_off_float: assert property (p_off_float) else $error("switch node driven while off");

    property p_fault_ss;
        @(posedge sys_clk) disable iff (!rst_b)
            q_reg.uv_s1 |=> q_reg.ss[0] == '0 && q_reg.ss[1] == '0;
    endproperty
    a_fault_ss: assert property (p_fault_ss) else $error("soft start not discharged");

    property p_hot_off;
        @(posedge sys_clk) disable iff (!rst_b)
            q_reg.hot |=> !q_reg.hs[0] && !q_reg.hs[1];
    endproperty
    a_hot_off: assert property (p_hot_off) else $error("switching while hot");

    property p_nostart;
        @(posedge sys_clk) disable iff (!rst_b)
            (q_reg.st[0] == buck_seq_pkg::CH_NOSTART && q_next.st[0] == buck_seq_pkg::CH_RUN)
            |-> q_reg.ns_cnt[0] == W'(NOSTART_CYCLES - 1);
    endproperty
    a_nostart: assert property (p_nostart) else $error("no-start interval wrong");

    property p_wait_pu;
        @(posedge sys_clk) disable iff (!rst_b)
            q_reg.st[1] == buck_seq_pkg::CH_NOSTART |-> q_reg.pu_done;
    endproperty
    a_wait_pu: assert property (p_wait_pu) else $error("no-start before power-up");

    property p_sync_fcm;
        @(posedge sys_clk) disable iff (!rst_b)
            q_reg.locked |-> active_mode == buck_seq_pkg::MODE_FCM;
    endproperty
    a_sync_fcm: assert property (p_sync_fcm) else $error("sync not forced continuous");

    property p_valley_skip;
        @(posedge sys_clk) disable iff (!rst_b)
            (cyc_start && feedback_sense1.valley_over) |=> !q_reg.hs[0];
    endproperty
    a_valley_skip: assert property (p_valley_skip) else $error("overload cycle not skipped");

    property p_zero_ls;
        @(posedge sys_clk) disable iff (!rst_b)
            (q_reg.ls[0] && active_mode != buck_seq_pkg::MODE_FCM
                && feedback_sense1.zero_current) |=> !q_reg.ls[0];
    endproperty
    a_zero_ls: assert property (p_zero_ls) else $error("low side on past zero current");

    property p_pg_fault;
        @(posedge sys_clk) disable iff (!rst_b)
            (q_reg.uv_s1 || q_reg.hot) |=> !q_reg.pg;
    endproperty
    a_pg_fault: assert property (p_pg_fault) else $error("power ok high during fault");
endmodule : dual_buck_sequencing_control

// >>> bench/buck_plant_model.sv
// converter plant and external clock source facing the sequencer
`timescale 1ns/10ps
module buck_plant_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // switch drives and scenario controls
    input wire buck_seq_pkg::sw_drive_t sw,
    input wire logic good,
    input wire logic ov,
    input wire logic overload,
    // comparator levels
    output buck_seq_pkg::ch_sense_t sense
);
    logic [3:0] on_reg;
    logic [3:0] off_reg;
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            on_reg <= 4'h0;
            off_reg <= 4'h0;
        end else begin
            on_reg <= sw.high_on ? ((on_reg == 4'hF) ? on_reg : on_reg + 4'h1) : 4'h0;
            off_reg <= sw.low_on ? ((off_reg == 4'hF) ? off_reg : off_reg + 4'h1) : 4'h0;
        end
    end
    always_comb begin
        // current ramps up while high side is on, down while low side is on
        sense.peak_trip = sw.high_on && (on_reg >= 4'h2);
        sense.zero_current = off_reg >= 4'h4;
        sense.reverse_limit = 1'b0;
        sense.valley_over = overload;
        sense.above_98 = good;
        sense.below_97 = !good;
        sense.above_110 = ov;
        sense.below_1078 = !ov;
        sense.above_target = good;
    end
endmodule : buck_plant_model

// external clock, still while not running
module sync_clock_source (
    // control
    input wire logic run,
    // clock out
    output logic clk
);
    initial clk = 1'b0;
    always #24 clk = run ? ~clk : 1'b0;
endmodule : sync_clock_source

// >>> bench/test_dual_buck_sequencing_control.sv
// self-checking bench for the dual buck sequencer
`timescale 1ns/10ps
module test_dual_buck_sequencing_control;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic en1 = 1'b0, en2 = 1'b0, uv = 1'b0, ot = 1'b0, m_lvl = 1'b0, m_flt = 1'b1;
    logic good1 = 1'b0, good2 = 1'b0, ov1 = 1'b0, ov2 = 1'b0, over1 = 1'b0, over2 = 1'b0;
    logic sync_run = 1'b0;
    logic sync_clk;
    buck_seq_pkg::ch_sense_t sense1, sense2;
    buck_seq_pkg::sw_drive_t sw1, sw2;
    logic [buck_seq_pkg::SST_W-1:0] ss1, ss2;
    logic locked, pg_out, pg_oe;
    buck_seq_pkg::mode_t mode;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    int n, h;
    logic [1:0] mpins [3] = '{2'b00, 2'b10, 2'b01};
    buck_seq_pkg::mode_t mexp [3] = '{buck_seq_pkg::MODE_SKIP, buck_seq_pkg::MODE_FCM,
        buck_seq_pkg::MODE_SLEEP};

    always #20 sys_clk = ~sys_clk;

    dual_buck_sequencing_control #(.POWERUP_CYCLES(20), .NOSTART_CYCLES(10), .PG_CYCLES(12),
        .LOSS_CYCLES(8)) DUT (.sys_clk(sys_clk), .rst_b(rst_b), .sync_clk(sync_clk),
        .chan1_enable_in(en1), .chan2_enable_in(en2), .input_undervoltage_lockout(uv),
        .overtemperature_flag(ot), .mode_level(m_lvl), .mode_floating(m_flt),
        .feedback_sense1(sense1), .feedback_sense2(sense2), .switch_node1(sw1),
        .switch_node2(sw2), .soft_start1(ss1), .soft_start2(ss2), .sync_locked(locked),
        .active_mode(mode), .power_ok_out(pg_out), .power_ok_oe(pg_oe));
    buck_plant_model plant1 (.sys_clk(sys_clk), .rst_b(rst_b), .sw(sw1), .good(good1),
        .ov(ov1), .overload(over1), .sense(sense1));
    buck_plant_model plant2 (.sys_clk(sys_clk), .rst_b(rst_b), .sw(sw2), .good(good2),
        .ov(ov2), .overload(over2), .sense(sense2));
    sync_clock_source ext_clk (.run(sync_run), .clk(sync_clk));

    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #2;
    endtask : tick

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // cycles until a channel's high side is on
    task automatic first_on(input int ch, input int lim, output int k);
        k = 0;
        while (k < lim && ((ch == 1) ? sw1.high_on : sw2.high_on) !== 1'b1) begin
            tick(1);
            k++;
        end
    endtask : first_on

    // cycles with a channel's high side on over a stretch
    task automatic count_on(input int ch, input int len, output int k);
        k = 0;
        repeat (len) begin
            tick(1);
            if (((ch == 1) ? sw1.high_on : sw2.high_on) !== 1'b0) k++;
        end
    endtask : count_on

    task automatic fault_test(input bit use_ot);
        if (use_ot) ot = 1'b1;
        else uv = 1'b1;
        tick(4);
        count_on(1, 20, h);
        check("high side 1 in fault", h[15:0], 16'h0000);
        check("ramp 1 in fault", {6'h00, ss1}, 16'h0000);
        check("ramp 2 in fault", {6'h00, ss2}, 16'h0000);
        check("pin pulled in fault", {15'h0000, pg_oe}, 16'h0001);
        ot = 1'b0;
        uv = 1'b0;
        tick(3);
        check("ramp 1 restarts", {15'h0000, ss1 < 10'h004}, 16'h0001);
        first_on(1, 60, n);
        check("switching resumes", {15'h0000, n < 60}, 16'h0001);
        $display("test fault %0d done", use_ot);
    endtask : fault_test

    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            final_report();
        end
    end

    initial begin
        tick(16);
        check("pin in reset", {15'h0000, pg_oe}, 16'h0001);
        check("node 1 floats", {15'h0000, sw1.drive_en}, 16'h0000);
        rst_b = 1'b1;
        tick(4);
        check("node 2 floats", {15'h0000, sw2.drive_en}, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            {m_flt, m_lvl} = mpins[i];
            tick(5);
            check("mode", {14'h0000, mode}, {14'h0000, mexp[i]});
        end
        {m_flt, m_lvl} = 2'b10;
        $display("test idle and modes done");
        // start from fully off, second enable inside power-up
        good1 = 1'b1;
        good2 = 1'b1;
        en1 = 1'b1;
        tick(5);
        en2 = 1'b1;
        first_on(1, 80, n);
        check("start 1 window", {15'h0000, n >= 25 && n <= 55}, 16'h0001);
        first_on(2, 80, h);
        check("start 2 after power-up", {15'h0000, n + 5 + h >= 30}, 16'h0001);
        while (sw1.high_on === 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        check("low side follows", {15'h0000, sw1.low_on}, 16'h0001);
        check("ramp 1 running", {15'h0000, ss1 != 10'h000}, 16'h0001);
        $display("test start-up done");
        // re-enable channel 2 while channel 1 runs
        en2 = 1'b0;
        tick(10);
        en2 = 1'b1;
        first_on(2, 80, n);
        check("no-start 2", {15'h0000, n >= 10 && n <= 29}, 16'h0001);
        first_on(1, 30, n);
        while (sw1.high_on === 1'b1) tick(1);
        first_on(1, 30, n);
        first_on(2, 30, n);
        check("phase offset", {15'h0000, n >= 4 && n <= 8}, 16'h0001);
        $display("test second channel done");
        tick(40);
        check("power ok high", {15'h0000, pg_oe}, 16'h0000);
        good1 = 1'b0;
        tick(8);
        check("glitch filtered", {15'h0000, pg_oe}, 16'h0000);
        tick(20);
        check("power ok low", {15'h0000, pg_oe}, 16'h0001);
        good1 = 1'b1;
        tick(8);
        check("rise delayed", {15'h0000, pg_oe}, 16'h0001);
        tick(20);
        check("power ok back", {15'h0000, pg_oe}, 16'h0000);
        ov1 = 1'b1;
        ov2 = 1'b1;
        count_on(2, 8, h);
        check("high side 2 off", h[15:0], 16'h0000);
        tick(20);
        check("overvoltage low", {15'h0000, pg_oe}, 16'h0001);
        ov1 = 1'b0;
        ov2 = 1'b0;
        tick(8);
        check("ov recover delayed", {15'h0000, pg_oe}, 16'h0001);
        tick(20);
        check("ov recovered", {15'h0000, pg_oe}, 16'h0000);
        $display("test power ok done");
        over1 = 1'b1;
        tick(16);
        count_on(1, 30, h);
        check("overload skips", h[15:0], 16'h0000);
        over1 = 1'b0;
        first_on(1, 40, n);
        check("overload ends", {15'h0000, n < 40}, 16'h0001);
        $display("test overload done");
        {m_flt, m_lvl} = 2'b00;
        tick(8);
        count_on(1, 30, h);
        check("skip at light load", h[15:0], 16'h0000);
        check("low side stops at zero", {15'h0000, sw1.low_on}, 16'h0000);
        {m_flt, m_lvl} = 2'b01;
        count_on(1, 30, h);
        check("sleep holds off", h[15:0], 16'h0000);
        good1 = 1'b0;
        first_on(1, 40, n);
        check("sleep wakes", {15'h0000, n < 40}, 16'h0001);
        good1 = 1'b1;
        {m_flt, m_lvl} = 2'b10;
        $display("test light load done");
        {m_flt, m_lvl} = 2'b00;
        sync_run = 1'b1;
        n = 0;
        while (locked !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        check("sync locked", {15'h0000, locked}, 16'h0001);
        check("sync forces fcm", {14'h0000, mode}, {14'h0000, buck_seq_pkg::MODE_FCM});
        sync_run = 1'b0;
        tick(4);
        check("loss not yet seen", {15'h0000, locked}, 16'h0001);
        tick(20);
        check("loss detected", {15'h0000, locked}, 16'h0000);
        check("mode after loss", {14'h0000, mode}, {14'h0000, buck_seq_pkg::MODE_SKIP});
        {m_flt, m_lvl} = 2'b10;
        $display("test sync done");
        fault_test(1'b1);
        fault_test(1'b0);
        en1 = 1'b0;
        en2 = 1'b0;
        tick(6);
        check("pin off when none", {15'h0000, pg_oe}, 16'h0001);
        check("open drain data low", {15'h0000, pg_out}, 16'h0000);
        check("nodes float", {14'h0000, sw1.drive_en, sw2.drive_en}, 16'h0000);
        $display("test disable done");
        final_report();
    end
endmodule : test_dual_buck_sequencing_control
